// File: frame_timer.sv
// Frame-start tick generator used in host mode.
// Assumes a single clock; restarts whenever disabled.
`default_nettype none

module frame_timer #(
    parameter int unsigned PERIOD = 40000
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic run,
    output logic      tick
);

    // Cycle counter
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic        tick_d;

    // ****************************************
    // Next count
    // ****************************************
    always_comb begin
        count_d = count_q;
        tick_d  = 1'b0;
        if (!run) begin
            count_d = 32'h0000_0000;
        end else if (count_q == 32'(PERIOD - 1)) begin
            count_d = 32'h0000_0000;
            tick_d  = 1'b1;
        end else begin
            count_d = count_q + 32'h0000_0001;
        end
    end

    // Register count and tick
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_q <= 32'h0000_0000;
            tick    <= 1'b0;
        end else begin
            count_q <= count_d;
            tick    <= tick_d;
        end
    end

endmodule

`default_nettype wire

// File: usb_peer_model.sv
// Far-side model: bus activity bursts and the core stop indication.
// Assumes the bench requests bursts; the core stops after the pins are released.
`default_nettype none

module usb_peer_model (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic burst,
    input  wire logic slow,
    input  wire logic pins_owned,
    output var  logic bus_activity,
    output var  logic core_idle
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [5:0] stop_q; // Cycles since the pins were released

    // Activity follows the burst request; the core stops promptly or slowly
    always @(posedge sys_clk) begin
        bus_activity <= burst & ~reset;
        if (reset) begin
            stop_q <= 6'h3F; // Core has long stopped while held in reset
        end else if (pins_owned) begin
            stop_q <= 6'h00;
        end else if (stop_q != 6'h3F) begin
            stop_q <= stop_q + 6'h01;
        end
        core_idle <= (stop_q > (slow ? 6'h1E : 6'h03));
    end
endmodule

`default_nettype wire

// File: usb_power_and_control_bench.sv
// Self-checking bench of the USB power and control block.
// Assumes the design files and the peer model are compiled before it.
`default_nettype none
`include "usb_power_defs.svh"
`define check_eq(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    n_errors++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module usb_power_and_control_bench import usb_power_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int FRAME = 50;  // Shortened frame period
    localparam int HOLD  = 200; // Shortened resume hold
    localparam logic [7:0] PW = `OFS_POWER_CONTROL, CT = `OFS_CONTROL;
    localparam logic [7:0] ST = `OFS_IRQ_STATUS, MK = `OFS_IRQ_MASK;
    typedef struct {logic [31:0] ex; logic [31:0] mk;} note_t;
    reg_req_t    req;        // Register port request
    logic        sys_clk, reset, burst, slow, rd_q, bus_activity, core_idle;
    logic [31:0] reg_rdata, rd_data, v;
    logic        usb_clk_enable, xcvr_low_power, module_enable, pins_owned;
    logic        analog_enable, pingpong_pointer_reset, frame_start_pulse;
    logic        resume_drive, ls_eop_drive, sleep_block, irq;
    int          n_errors, samples_checked, pend_seen, n_pp, n_sof, n_eop, cyc_n, last_sof;
    note_t       notes[$];   // Expected read answers, oldest first
    note_t       n;
    logic [7:0]  ofs [5] = '{PW, CT, ST, MK, 8'h10}; // Last one unmapped

    usb_power_control #(.FRAME_CYCLES(FRAME), .SETTLE(4)) usb_power_control_i (
        .sys_clk, .reset, .reg_addr(req.addr), .reg_wdata(req.wdata), .reg_wr(req.wr),
        .reg_rd(req.rd), .reg_rdata, .bus_activity, .core_idle, .usb_clk_enable,
        .xcvr_low_power, .module_enable, .pins_owned, .analog_enable,
        .pingpong_pointer_reset, .frame_start_pulse, .resume_drive, .ls_eop_drive,
        .sleep_block, .irq);
    usb_peer_model usb_peer_model_i (.sys_clk, .reset, .burst, .slow, .pins_owned,
        .bus_activity, .core_idle);

    // 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Bus cycles and reporting
    // ****************************************
    task automatic cyc(input int k);
        req <= '0;
        repeat (k) @(posedge sys_clk);
    endtask
    // Block registers only; no token command is ever issued
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
        notes.push_back(note_t'{ex, mk});
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Output watcher: pulse counters and read answers against the notes
    always @(posedge sys_clk) begin
        cyc_n++;
        if (pingpong_pointer_reset === 1'b1) n_pp++;
        if (ls_eop_drive === 1'b1) n_eop++;
        if (frame_start_pulse === 1'b1) begin
            if (last_sof != 0) `check_eq("sof_gap", FRAME, cyc_n - last_sof)
            last_sof = cyc_n;
            n_sof++;
        end
        if (rd_q) begin
            rd_data = reg_rdata;
            if (reg_rdata[`PENDING_BIT] === 1'b1) pend_seen++;
            n = notes.pop_front();
            `check_eq("rdata", n.ex & n.mk, reg_rdata & n.mk)
        end
        rd_q <= req.rd;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        stop_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        req = '0;
        {burst, slow} = 2'b00;
        reset = 1'b1;
        {n_errors, samples_checked, pend_seen, n_pp, n_sof, n_eop, cyc_n, last_sof} = '0;
        void'($urandom(23));
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        foreach (ofs[i]) rd(ofs[i], 32'h0, 32'hFFFF_FFFB);
        cyc(2);
        `check_eq("xcvr_lp", 1'b1, xcvr_low_power);
        `check_eq("pins", 1'b0, pins_owned | analog_enable | usb_clk_enable);
        done("reset");
        wr(PW, 32'h0000_0089);
        cyc(8);
        rd(PW, 32'h0000_0009, 32'hFFFF_FFFF);
        `check_eq("on", 4'hB, {usb_clk_enable, xcvr_low_power, pins_owned, analog_enable});
        repeat (8) begin
            v = $urandom & 32'h0000_0012;
            wr(PW, v | 32'h1);
            rd(PW, v | 32'h9, 32'hFFFF_FFFF);
            cyc(1);
            `check_eq("susp", {~v[1], v[1], 1'b0}, {usb_clk_enable, xcvr_low_power, sleep_block});
        end
        wr(PW, 32'h1);
        done("suspend");
        wr(CT, 32'h1);
        n_sof = 0;
        cyc(2 * FRAME);
        `check_eq("dev_en", 1'b1, module_enable);
        `check_eq("dev_sof", 0, n_sof);
        wr(CT, 32'h0);
        cyc(1);
        `check_eq("dev_off", 1'b0, module_enable);
        n_pp = 0;
        wr(CT, 32'h2);
        wr(CT, 32'h2);
        rd(CT, 32'h0, 32'hFFFF_FFFF);
        cyc(3);
        `check_eq("pp_cnt", 2, n_pp);
        done("control");
        wr(MK, 32'h2);
        last_sof = 0;
        n_sof = 0;
        wr(CT, 32'h9);
        cyc(5 * FRAME);
        `check_eq("sof_cnt", 1'b1, n_sof >= 4);
        `check_eq("sof_irq", 1'b1, irq);
        wr(CT, 32'h8);
        cyc(2);
        n_sof = 0;
        cyc(3 * FRAME);
        `check_eq("sof_off", 0, n_sof);
        wr(ST, 32'h2);
        cyc(1);
        `check_eq("irq_clr", 1'b0, irq);
        done("frames");
        wr(MK, 32'h1);
        wr(PW, 32'h11);
        pend_seen = 0;
        burst <= 1'b1;
        repeat (10) rd(PW, 32'h19, 32'hFFFF_FF7F);
        cyc(2);
        `check_eq("pend_once", 1, pend_seen);
        `check_eq("guard_on", 2'b11, {sleep_block, irq});
        wr(PW, 32'h1);
        cyc(1);
        `check_eq("guard_off", 1'b0, sleep_block);
        burst <= 1'b0;
        wr(PW, 32'h11);
        cyc(8);
        `check_eq("quiet", 1'b0, sleep_block);
        wr(ST, 32'h1);
        cyc(1);
        `check_eq("act_clr", 1'b0, irq);
        done("activity");
        wr(CT, 32'hC);
        cyc(HOLD);
        `check_eq("resume", 1'b1, resume_drive);
        n_eop = 0;
        wr(CT, 32'h8);
        cyc(`EOP_CYCLES + 4);
        `check_eq("eop_host", `EOP_CYCLES, n_eop);
        wr(CT, 32'h4);
        cyc(HOLD);
        n_eop = 0;
        wr(CT, 32'h0);
        cyc(`EOP_CYCLES + 4);
        `check_eq("eop_dev", 0, n_eop);
        done("resume");
        slow <= 1'b1;
        wr(PW, 32'h0);
        cyc(8);
        rd(PW, 32'h8, 32'hFFFF_FFFF);
        rd_data = 32'h8;
        for (int i = 0; i < 100 && rd_data[3] !== 1'b0; i++) begin
            rd(PW, 32'h0, 32'hFFFF_FFF7);
            cyc(2);
        end
        `check_eq("busy_end", 1'b0, rd_data[3]);
        `check_eq("off", 2'b00, {pins_owned, resume_drive});
        rd(ST, 32'h4, 32'h4);
        `check_eq("ready_masked", 1'b0, irq);
        wr(MK, 32'h4);
        cyc(1);
        `check_eq("ready_irq", 1'b1, irq);
        wr(ST, 32'h4);
        cyc(1);
        `check_eq("ready_clr", 1'b0, irq);
        done("power_down");
        stop_test();
    end
endmodule

`default_nettype wire

// File: usb_power_control.sv
// Power, suspend, enable, frame-start and resume control of a USB controller.
// Assumes bus activity and core idle come from other domains; both are synchronised here.
`default_nettype none
`include "usb_power_defs.svh"

module usb_power_control
    import usb_power_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = `FRAME_CYCLES,
    parameter int unsigned SETTLE       = `SETTLE_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        bus_activity,
    input  wire logic        core_idle,
    output logic             usb_clk_enable,
    output logic             xcvr_low_power,
    output logic             module_enable,
    output logic             pins_owned,
    output logic             analog_enable,
    output logic             pingpong_pointer_reset,
    output logic             frame_start_pulse,
    output logic             resume_drive,
    output logic             ls_eop_drive,
    output logic             sleep_block,
    output logic             irq
);

    // ****************************************
    // Declarations
    // ****************************************
    reg_req_t    req;            // Bundled register request
    logic [31:0] power_q, power_d;     // Power control bits
    logic [31:0] control_q, control_d; // Control bits
    logic [`IRQ_WIDTH-1:0] status_q, status_d; // Sticky events
    logic [`IRQ_WIDTH-1:0] mask_q, mask_d;     // Interrupt mask
    logic        pending_q, pending_d;        // Activity pending
    logic        act_s1_q, act_s2_q, act_s3_q; // Activity sync
    logic        idle_s1_q, idle_s2_q;         // Idle sync
    pwr_state_t  state_q, state_d;             // Power sequencer
    logic [15:0] settle_q, settle_d;           // Settle counter
    logic [3:0]  eop_q, eop_d;                 // EOP counter
    logic [31:0] rdata_d;                      // Read mux
    logic        activity_rise;                // Bus activity edge
    logic        frame_tick;                   // Frame tick
    logic        host_mode;                    // Host mode select
    logic        pow_on;                       // Power bit
    logic        busy;                         // Not-ready flag
    logic        pp_d, fs_d;                   // Pulse next values

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Write decode helper
    function automatic logic wr_hit(input reg_req_t r, input logic [7:0] ofs);
        wr_hit = r.wr && (r.addr == ofs);
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            act_s1_q  <= 1'b0;
            act_s2_q  <= 1'b0;
            act_s3_q  <= 1'b0;
            idle_s1_q <= 1'b1;
            idle_s2_q <= 1'b1;
        end else begin
            act_s1_q  <= bus_activity;
            act_s2_q  <= act_s1_q;
            act_s3_q  <= act_s2_q;
            idle_s1_q <= core_idle;
            idle_s2_q <= idle_s1_q;
        end
    end

    assign activity_rise = act_s2_q && !act_s3_q;
    assign host_mode     = control_q[`HOSTMODE_BIT];
    assign pow_on        = power_q[`POW_ON_BIT];

    // ****************************************
    // Frame-start timer
    // ****************************************
    frame_timer #(
        .PERIOD (FRAME_CYCLES)
    ) u_frame (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (pow_on && host_mode && control_q[`ENABLE_BIT]),
        .tick    (frame_tick)
    );

    // ****************************************
    // Power sequencer next state
    // ****************************************
    always_comb begin
        state_d  = state_q;
        settle_d = settle_q;
        case (state_q)
            PWR_OFF: begin
                if (pow_on) begin
                    state_d  = PWR_STARTING;
                    settle_d = 16'(SETTLE);
                end
            end
            PWR_STARTING: begin
                if (settle_q != 16'h0000) begin
                    settle_d = settle_q - 16'h0001;
                end else begin
                    state_d = PWR_ON;
                end
            end
            PWR_ON: begin
                if (!pow_on) begin
                    state_d  = PWR_STOPPING;
                    settle_d = 16'(SETTLE);
                end
            end
            PWR_STOPPING: begin
                // Wait for settle time and core to go idle
                if (settle_q != 16'h0000) begin
                    settle_d = settle_q - 16'h0001;
                end else if (idle_s2_q) begin
                    state_d = PWR_OFF;
                end
            end
            default: begin
                state_d = PWR_OFF;
            end
        endcase
    end

    // Busy while the sequencer is not in PWR_OFF, or while the core is not idle
    assign busy = (state_q != PWR_OFF) || !idle_s2_q;

    // ****************************************
    // Register and event next values
    // ****************************************
    always_comb begin
        power_d   = power_q;
        control_d = control_q;
        mask_d    = mask_q;
        status_d  = status_q;
        pending_d = pending_q;
        eop_d     = (eop_q != 4'h0) ? eop_q - 4'h1 : 4'h0;
        pp_d      = 1'b0;
        fs_d      = frame_tick;
        // Only guard, suspend and power bits are writable
        if (wr_hit(req, `OFS_POWER_CONTROL)) begin
            power_d[`POW_ON_BIT]  = req.wdata[`POW_ON_BIT];
            power_d[`SUSPEND_BIT] = req.wdata[`SUSPEND_BIT];
            power_d[`GUARD_BIT]   = req.wdata[`GUARD_BIT];
        end
        if (wr_hit(req, `OFS_CONTROL)) begin
            control_d = req.wdata & 32'h0000_000D;
            pp_d      = req.wdata[`PPRESET_BIT];
            // Resume released in host mode
            if (control_q[`RESUME_BIT] && !req.wdata[`RESUME_BIT] && host_mode) begin
                eop_d = 4'(`EOP_CYCLES);
            end
        end
        if (wr_hit(req, `OFS_IRQ_MASK)) begin
            mask_d = req.wdata[`IRQ_WIDTH-1:0];
        end
        if (wr_hit(req, `OFS_IRQ_STATUS)) begin
            status_d = status_q & ~req.wdata[`IRQ_WIDTH-1:0];
        end
        // Activity arrives as pending; clears once interrupt raised
        if (pending_q) begin
            pending_d = 1'b0;
            status_d[`IRQ_ACTIVITY_BIT] = 1'b1;
        end
        if (activity_rise) begin
            pending_d = 1'b1;
        end
        // Hardware sets win over software clears
        if (fs_d) begin
            status_d[`IRQ_FRAME_BIT] = 1'b1;
        end
        if (state_q == PWR_STOPPING && state_d == PWR_OFF) begin
            status_d[`IRQ_READY_BIT] = 1'b1;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (req.addr)
            `OFS_POWER_CONTROL: begin
                rdata_d = power_q;
                rdata_d[`NOT_READY_BIT] = busy;
                rdata_d[`PENDING_BIT]   = pending_q;
            end
            `OFS_CONTROL:    rdata_d = control_q;
            `OFS_IRQ_STATUS: rdata_d = {29'h0, status_q};
            `OFS_IRQ_MASK:   rdata_d = {29'h0, mask_q};
            default:         rdata_d = 32'h0000_0000;
        endcase
        if (!req.rd) begin
            rdata_d = 32'h0000_0000;
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            power_q   <= `POWER_RESET;
            control_q <= `CONTROL_RESET;
            status_q  <= '0;
            mask_q    <= '0;
            pending_q <= 1'b0;
            state_q   <= PWR_OFF;
            settle_q  <= 16'h0000;
            eop_q     <= 4'h0;
            reg_rdata <= 32'h0000_0000;
            pingpong_pointer_reset <= 1'b0;
            frame_start_pulse      <= 1'b0;
        end else begin
            power_q   <= power_d;
            control_q <= control_d;
            status_q  <= status_d;
            mask_q    <= mask_d;
            pending_q <= pending_d;
            state_q   <= state_d;
            settle_q  <= settle_d;
            eop_q     <= eop_d;
            reg_rdata <= rdata_d;
            pingpong_pointer_reset <= pp_d;
            frame_start_pulse      <= fs_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign module_enable  = pow_on && !host_mode && control_q[`ENABLE_BIT];
    assign pins_owned     = pow_on;
    assign analog_enable  = pow_on;
    assign usb_clk_enable = pow_on && !power_q[`SUSPEND_BIT];
    assign xcvr_low_power = !pow_on || power_q[`SUSPEND_BIT];
    assign resume_drive   = pow_on && control_q[`RESUME_BIT];
    assign ls_eop_drive   = pow_on && (eop_q != 4'h0);
    assign sleep_block    = power_q[`GUARD_BIT] && (act_s2_q || pending_q);
    assign irq            = |(status_q & mask_q);

    // ****************************************
    // Checks
    // ****************************************
    pending_set_a: assert property (@(posedge sys_clk) disable iff (reset)
        activity_rise |=> pending_q) else $error("pending not set");
    pending_clr_a: assert property (@(posedge sys_clk) disable iff (reset)
        pending_q && !activity_rise |=> !pending_q && status_q[0])
        else $error("pending not cleared");
    sleep_guard_a: assert property (@(posedge sys_clk) disable iff (reset)
        !power_q[4] |-> !sleep_block) else $error("sleep blocked unguarded");
    busy_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(pow_on) |=> busy[*3]) else $error("busy not shown");
    clock_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
        power_q[1] |-> !usb_clk_enable && xcvr_low_power)
        else $error("clock not gated");
    power_off_a: assert property (@(posedge sys_clk) disable iff (reset)
        !pow_on |-> !module_enable && !pins_owned && !analog_enable && !resume_drive)
        else $error("outputs active while off");
    pp_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
        reg_wr && reg_addr == 8'h04 && reg_wdata[1] |=> pingpong_pointer_reset)
        else $error("pointer reset missing");
    dev_enable_a: assert property (@(posedge sys_clk) disable iff (reset)
        pow_on && !control_q[3] && control_q[0] |-> module_enable)
        else $error("device enable missing");
    // Tick pipeline is two deep, so the enable must have been low three samples
    frame_off_a: assert property (@(posedge sys_clk) disable iff (reset)
        !control_q[0] && !$past(control_q[0]) && !$past(control_q[0], 2)
        |-> !frame_start_pulse)
        else $error("frame start while disabled");
    // Host mode as it stood when the resume bit was written low
    eop_tail_a: assert property (@(posedge sys_clk) disable iff (reset)
        pow_on && $past(host_mode) && $fell(control_q[2]) |-> ls_eop_drive[*7])
        else $error("eop not appended");

endmodule

`default_nettype wire

// File: usb_power_defs.svh
// Offsets, field positions, reset values and timing counts of the USB power and control block.
// Assumes a 40 MHz system clock and a plain byte-addressed register port.
`ifndef USB_POWER_DEFS_SVH
`define USB_POWER_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_POWER_CONTROL   8'h00
`define OFS_CONTROL         8'h04
`define OFS_IRQ_STATUS      8'h08
`define OFS_IRQ_MASK        8'h0C

// ****************************************
// Power control fields
// ****************************************
`define POW_ON_BIT          0
`define SUSPEND_BIT         1
`define NOT_READY_BIT       3
`define GUARD_BIT           4
`define PENDING_BIT         7

// ****************************************
// Control fields
// ****************************************
`define ENABLE_BIT          0
`define PPRESET_BIT         1
`define RESUME_BIT          2
`define HOSTMODE_BIT        3

// ****************************************
// Interrupt status fields
// ****************************************
`define IRQ_ACTIVITY_BIT    0
`define IRQ_FRAME_BIT       1
`define IRQ_READY_BIT       2
`define IRQ_WIDTH           3

// ****************************************
// Reset values and timing
// ****************************************
`define POWER_RESET         32'h0000_0000
`define CONTROL_RESET       32'h0000_0000
`define CLK_HZ              40000000
`define FRAME_PERIOD_US     1000
`define FRAME_CYCLES        ((`CLK_HZ / 1000000) * `FRAME_PERIOD_US)
`define SETTLE_CYCLES       16
`define EOP_CYCLES          8

`endif

// File: usb_power_pkg.sv
// Types shared by the USB power and control block.
// Assumes usb_power_defs.svh is compiled alongside.
`default_nettype none

package usb_power_pkg;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Sequencer states for power-up and power-down
    typedef enum logic [3:0] {
        PWR_OFF      = 4'b0001,
        PWR_STARTING = 4'b0010,
        PWR_ON       = 4'b0100,
        PWR_STOPPING = 4'b1000
    } pwr_state_t;

endpackage

`default_nettype wire
